// [include/aspf_defs.svh]
// Constants for the asynchronous serial port: register offsets, field positions,
// reset values and timing counts. Definitions only; included by the port and its FIFO.
// Function
// - Frame is start, data LSB first, parity, stop.
// - Five to eight data bits, both directions.
// - Even, odd, stick or no parity; 1/2 stops.
// - Divisor is 16-bit integer plus 6-bit fraction.
// - Tick at sixteen times baud; transmit divides.
// - Divisor and line settings latched on line write.
// - Transmit and receive enables, both set at reset.
// - Disable finishes current character before stopping.
// - Send while transmit FIFO holds data and enabled.
// - Busy until FIFO empty and shifter finished.
// - Start bit confirmed low at eighth tick.
// - Data sampled every sixteenth tick, then parity.
// - High stop valid else framing error; store word.
// - Sixteen-entry FIFOs; receive entries carry four flags.
// - Data read twelve bits, write pushes eight.
// - FIFOs single entry until FIFO enable set.
// - Empty, full flags and separate overrun status bit.
// - Trigger levels eighth through seven eighths, each FIFO.
// - Both trigger levels reset to one half.
`ifndef ASPF_DEFS_SVH
`define ASPF_DEFS_SVH

`define ASPF_OFF_DATA 12'h000
`define ASPF_OFF_RSR 12'h004
`define ASPF_OFF_FLAG 12'h018
`define ASPF_OFF_IBRD 12'h024
`define ASPF_OFF_FBRD 12'h028
`define ASPF_OFF_LCRH 12'h02C
`define ASPF_OFF_CTL 12'h030
`define ASPF_OFF_IFLS 12'h034
`define ASPF_OFF_LEVEL 12'h048

`define ASPF_LCR_BRK 0
`define ASPF_LCR_PEN 1
`define ASPF_LCR_EPS 2
`define ASPF_LCR_STP2 3
`define ASPF_LCR_FEN 4
`define ASPF_LCR_WLEN_LO 5
`define ASPF_LCR_SPS 7

`define ASPF_CTL_EN 0
`define ASPF_CTL_TXE 8
`define ASPF_CTL_RXE 9
`define ASPF_CTL_RESET 10'h300
`define ASPF_IFLS_RESET 6'h12

`define ASPF_FIFO_DEPTH 16
`define ASPF_FIFO_AW 4
`define ASPF_OVS_TICKS 16
`define ASPF_START_TICK 4'h7

`endif

// [include/aspf_pkg.sv]
// Types shared by the asynchronous serial port and its FIFO.
// Assumes nothing beyond a SystemVerilog compiler.
package aspf_pkg;
  typedef enum logic [2:0] {ASPF_IDLE, ASPF_START, ASPF_DATA, ASPF_PAR, ASPF_STOP} aspf_state_type;
  typedef logic [11:0] aspf_addr_type;
  typedef logic [31:0] aspf_word_type;
endpackage

// [core/aspf_fifo.sv]
// Flip-flop FIFO of sixteen entries whose usable depth can shrink to one.
// Assumes push is not asserted while full and pop not while empty.
`timescale 1ns/1ns
`include "aspf_defs.svh"
module aspf_fifo #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Control
  input wire logic deep_in,
  input wire logic push_in,
  input wire logic [WIDTH-1:0] push_data_in,
  input wire logic pop_in,
  // Status
  output logic [WIDTH-1:0] head_out,
  output logic empty_out,
  output logic full_out,
  output logic [4:0] count_out
);
  import aspf_pkg::*;
  logic [WIDTH-1:0] mem_q [`ASPF_FIFO_DEPTH];
  logic [`ASPF_FIFO_AW-1:0] wr_q;
  logic [`ASPF_FIFO_AW-1:0] rd_q;
  logic [4:0] cnt_q;

  always_ff @(posedge clk_sys_in)
  begin
    if (push_in)
    begin
      mem_q[wr_q] <= push_data_in;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      wr_q <= 4'h0;
      rd_q <= 4'h0;
      cnt_q <= 5'h00;
    end
    else
    begin
      if (push_in)
      begin
        wr_q <= wr_q + 4'h1;
      end
      if (pop_in)
      begin
        rd_q <= rd_q + 4'h1;
      end
      if (push_in && !pop_in)
      begin
        cnt_q <= cnt_q + 5'h01;
      end
      else if (pop_in && !push_in)
      begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end

  assign head_out = mem_q[rd_q];
  assign empty_out = (cnt_q == 5'h00);
  // Holding-register mode: one entry counts as full
  assign full_out = deep_in ? (cnt_q == 5'h10) : (cnt_q != 5'h00);
  assign count_out = cnt_q;
endmodule // aspf_fifo

// [core/aspf_port.sv]
// Asynchronous serial port: register port, fractional baud generator,
// transmitter, receiver and two FIFOs.
// Assumes a register master with one-cycle strobes and a synchronous receive line.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`include "aspf_defs.svh"
module aspf_port (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Register port
  input wire aspf_pkg::aspf_addr_type reg_addr_in,
  input wire aspf_pkg::aspf_word_type reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output aspf_pkg::aspf_word_type reg_rdata_out,
  // Serial lines
  input wire logic serial_in_line_in,
  output logic serial_out_line_out,
  // Status
  output logic busy_out,
  output logic tx_level_hit_out,
  output logic rx_level_hit_out
);
  import aspf_pkg::*;

  logic [15:0] integer_divisor_reg_q;
  logic [5:0] fraction_divisor_reg_q;
  logic [7:0] line_control_reg_q;
  logic [29:0] active_cfg_q;
  logic [9:0] control_reg_q;
  logic [5:0] fifo_level_select_reg_q;
  logic overrun_q;
  aspf_word_type rdata_q;

  logic [15:0] div_int;
  logic [5:0] div_frac;
  logic brk_send, pen, eps, stp2, fifo_enable_bit, sps;
  logic [1:0] wlen;
  logic [3:0] nbits;
  logic module_enable, transmit_enable_bit, receive_enable_bit;
  assign {div_int, div_frac} = active_cfg_q[29:8];
  assign brk_send = active_cfg_q[`ASPF_LCR_BRK];
  assign pen = active_cfg_q[`ASPF_LCR_PEN];
  assign eps = active_cfg_q[`ASPF_LCR_EPS];
  assign stp2 = active_cfg_q[`ASPF_LCR_STP2];
  assign fifo_enable_bit = active_cfg_q[`ASPF_LCR_FEN];
  assign wlen = active_cfg_q[`ASPF_LCR_WLEN_LO +: 2];
  assign sps = active_cfg_q[`ASPF_LCR_SPS];
  assign nbits = 4'h5 + {2'b00, wlen};
  assign module_enable = control_reg_q[`ASPF_CTL_EN];
  assign transmit_enable_bit = control_reg_q[`ASPF_CTL_TXE];
  assign receive_enable_bit = control_reg_q[`ASPF_CTL_RXE];

  logic wr_data, rd_data;
  assign wr_data = reg_write_in && (reg_addr_in == `ASPF_OFF_DATA);
  assign rd_data = reg_read_in && (reg_addr_in == `ASPF_OFF_DATA);

  // FIFOs
  logic tx_pop, tx_empty, tx_full, rx_push, rx_pop, rx_empty, rx_full;
  logic [7:0] tx_head;
  logic [11:0] rx_head, rx_word;
  logic [4:0] tx_count, rx_count;
  logic tx_push;
  assign tx_push = wr_data && !tx_full;
  assign rx_pop = rd_data && !rx_empty;

  aspf_fifo #(.WIDTH(8)) tx_fifo (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .deep_in(fifo_enable_bit),
    .push_in(tx_push),
    .push_data_in(reg_wdata_in[7:0]),
    .pop_in(tx_pop),
    .head_out(tx_head),
    .empty_out(tx_empty),
    .full_out(tx_full),
    .count_out(tx_count)
  );

  aspf_fifo #(.WIDTH(12)) rx_fifo (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .deep_in(fifo_enable_bit),
    .push_in(rx_push),
    .push_data_in(rx_word),
    .pop_in(rx_pop),
    .head_out(rx_head),
    .empty_out(rx_empty),
    .full_out(rx_full),
    .count_out(rx_count)
  );

  // Registers; line control write latches the whole 30-bit setting
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      integer_divisor_reg_q <= 16'h0000;
      fraction_divisor_reg_q <= 6'h00;
      line_control_reg_q <= 8'h00;
      active_cfg_q <= 30'h00000000;
      control_reg_q <= `ASPF_CTL_RESET;
      fifo_level_select_reg_q <= `ASPF_IFLS_RESET;
    end
    else if (reg_write_in)
    begin
      case (reg_addr_in)
        `ASPF_OFF_IBRD: integer_divisor_reg_q <= reg_wdata_in[15:0];
        `ASPF_OFF_FBRD: fraction_divisor_reg_q <= reg_wdata_in[5:0];
        `ASPF_OFF_LCRH:
        begin
          line_control_reg_q <= reg_wdata_in[7:0];
          active_cfg_q <= {integer_divisor_reg_q, fraction_divisor_reg_q,
                           reg_wdata_in[7:0]};
        end
        `ASPF_OFF_CTL: control_reg_q <= reg_wdata_in[9:0];
        `ASPF_OFF_IFLS: fifo_level_select_reg_q <= reg_wdata_in[5:0];
        default: ;
      endcase
    end
  end

  // Fractional baud generator: accumulate in 1/64 units, one tick per divisor
  logic [21:0] baud_acc_q;
  logic oversample_tick;
  logic [21:0] div_full;
  assign div_full = {div_int, div_frac};
  assign oversample_tick = (div_int != 16'h0000) && (baud_acc_q + 22'h000040 >= div_full);

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      baud_acc_q <= 22'h000000;
    end
    else if (oversample_tick)
    begin
      baud_acc_q <= baud_acc_q + 22'h000040 - div_full;
    end
    else
    begin
      baud_acc_q <= baud_acc_q + 22'h000040;
    end
  end

  // Transmitter
  aspf_state_type tx_state_q;
  logic [3:0] tx_tick_q;
  logic [3:0] tx_bit_q;
  logic [7:0] tx_shift_q;
  logic tx_par_q;
  logic tx_line_q;
  logic tx_bit_end;
  assign tx_bit_end = oversample_tick && (tx_tick_q == 4'hF);
  assign tx_pop = (tx_state_q == ASPF_IDLE) && !tx_empty && module_enable &&
                  transmit_enable_bit;

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      tx_state_q <= ASPF_IDLE;
      tx_tick_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_shift_q <= 8'h00;
      tx_par_q <= 1'b0;
      tx_line_q <= 1'b1;
    end
    else
    begin
      if (oversample_tick)
      begin
        tx_tick_q <= tx_tick_q + 4'h1;
      end
      case (tx_state_q)
        ASPF_IDLE:
        begin
          tx_line_q <= 1'b1;
          if (tx_pop)
          begin
            tx_shift_q <= tx_head;
            tx_par_q <= 1'b0;
            tx_tick_q <= 4'h0;
            tx_line_q <= 1'b0;
            tx_state_q <= ASPF_START;
          end
        end
        ASPF_START:
        begin
          if (tx_bit_end)
          begin
            tx_bit_q <= 4'h0;
            tx_line_q <= tx_shift_q[0];
            tx_state_q <= ASPF_DATA;
          end
        end
        ASPF_DATA:
        begin
          if (tx_bit_end)
          begin
            tx_par_q <= tx_par_q ^ tx_shift_q[0];
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == nbits - 4'h1)
            begin
              if (pen)
              begin
                // Stick parity sends the inverted even-select bit
                tx_line_q <= sps ? !eps : (tx_par_q ^ tx_shift_q[0] ^ !eps);
                tx_state_q <= ASPF_PAR;
              end
              else
              begin
                tx_line_q <= 1'b1;
                tx_bit_q <= 4'h0;
                tx_state_q <= ASPF_STOP;
              end
            end
            else
            begin
              tx_line_q <= tx_shift_q[1];
            end
          end
        end
        ASPF_PAR:
        begin
          if (tx_bit_end)
          begin
            tx_line_q <= 1'b1;
            tx_bit_q <= 4'h0;
            tx_state_q <= ASPF_STOP;
          end
        end
        ASPF_STOP:
        begin
          if (tx_bit_end)
          begin
            tx_bit_q <= tx_bit_q + 4'h1;
            if (!stp2 || tx_bit_q == 4'h1)
            begin
              tx_state_q <= ASPF_IDLE;
            end
          end
        end
        default: tx_state_q <= ASPF_IDLE;
      endcase
    end
  end

  // Break forces the line low regardless of the shifter
  assign serial_out_line_out = tx_line_q && !brk_send;
  assign busy_out = !tx_empty || (tx_state_q != ASPF_IDLE);

  // Receiver
  aspf_state_type rx_state_q;
  logic [3:0] rx_tick_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_shift_q;
  logic rx_par_err_q;
  logic rx_all_low_q;
  logic rx_sample;
  logic [7:0] rx_data_aligned;
  logic rx_frame_err, rx_break;
  assign rx_sample = oversample_tick && (rx_tick_q == `ASPF_START_TICK);
  assign rx_data_aligned = rx_shift_q >> (4'h8 - nbits);
  assign rx_frame_err = !serial_in_line_in;
  assign rx_break = rx_all_low_q && !serial_in_line_in;
  // Flags: break, overrun, parity, framing above the character
  // Parity accumulates every data bit, so it only counts as an error with parity on
  assign rx_word = {rx_break, rx_full, pen && rx_par_err_q, rx_frame_err, rx_data_aligned};
  assign rx_push = rx_sample && (rx_state_q == ASPF_STOP) && !rx_full;

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      rx_state_q <= ASPF_IDLE;
      rx_tick_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_shift_q <= 8'h00;
      rx_par_err_q <= 1'b0;
      rx_all_low_q <= 1'b0;
    end
    else
    begin
      if (oversample_tick)
      begin
        rx_tick_q <= rx_tick_q + 4'h1;
      end
      case (rx_state_q)
        ASPF_IDLE:
        begin
          if (!serial_in_line_in && module_enable && receive_enable_bit)
          begin
            rx_tick_q <= 4'h0;
            rx_state_q <= ASPF_START;
          end
        end
        ASPF_START:
        begin
          if (rx_sample)
          begin
            rx_bit_q <= 4'h0;
            rx_par_err_q <= 1'b0;
            rx_all_low_q <= 1'b1;
            // A glitch shorter than half a bit is dropped
            rx_state_q <= serial_in_line_in ? ASPF_IDLE : ASPF_DATA;
          end
        end
        ASPF_DATA:
        begin
          if (rx_sample)
          begin
            rx_shift_q <= {serial_in_line_in, rx_shift_q[7:1]};
            rx_par_err_q <= rx_par_err_q ^ serial_in_line_in;
            rx_all_low_q <= rx_all_low_q && !serial_in_line_in;
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == nbits - 4'h1)
            begin
              rx_state_q <= pen ? ASPF_PAR : ASPF_STOP;
            end
          end
        end
        ASPF_PAR:
        begin
          if (rx_sample)
          begin
            // Error bit ends high when the received parity disagrees
            rx_par_err_q <= sps ? (serial_in_line_in != !eps)
                                : (rx_par_err_q ^ serial_in_line_in ^ !eps);
            rx_all_low_q <= rx_all_low_q && !serial_in_line_in;
            rx_state_q <= ASPF_STOP;
          end
        end
        ASPF_STOP:
        begin
          if (rx_sample)
          begin
            rx_state_q <= ASPF_IDLE;
          end
        end
        default: rx_state_q <= ASPF_IDLE;
      endcase
    end
  end

  // Overrun: a word arrived with no room; set wins over a clearing write
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      overrun_q <= 1'b0;
    end
    else if (rx_sample && (rx_state_q == ASPF_STOP) && rx_full)
    begin
      overrun_q <= 1'b1;
    end
    else if (reg_write_in && reg_addr_in == `ASPF_OFF_RSR)
    begin
      overrun_q <= 1'b0;
    end
  end

  // Trigger levels: 0..4 select 2,4,8,12,14 entries of sixteen
  function automatic logic [4:0] aspf_level(input logic [2:0] sel);
    case (sel)
      3'h0: aspf_level = 5'h02;
      3'h1: aspf_level = 5'h04;
      3'h2: aspf_level = 5'h08;
      3'h3: aspf_level = 5'h0C;
      default: aspf_level = 5'h0E;
    endcase
  endfunction
  assign tx_level_hit_out = fifo_enable_bit ? (tx_count <= aspf_level(fifo_level_select_reg_q[2:0]))
                                : tx_empty;
  assign rx_level_hit_out = fifo_enable_bit ? (rx_count >= aspf_level(fifo_level_select_reg_q[5:3]))
                                : !rx_empty;

  // Read data, valid the cycle after the read strobe
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (reg_read_in)
    begin
      case (reg_addr_in)
        `ASPF_OFF_DATA: rdata_q <= {20'h00000, rx_head};
        `ASPF_OFF_RSR: rdata_q <= {28'h0000000, overrun_q, rx_head[11], rx_head[9:8]};
        `ASPF_OFF_FLAG: rdata_q <= {24'h000000, tx_empty, rx_full, tx_full, rx_empty,
                                    busy_out, 3'h0};
        `ASPF_OFF_IBRD: rdata_q <= {16'h0000, integer_divisor_reg_q};
        `ASPF_OFF_FBRD: rdata_q <= {26'h0000000, fraction_divisor_reg_q};
        `ASPF_OFF_LCRH: rdata_q <= {24'h000000, line_control_reg_q};
        `ASPF_OFF_CTL: rdata_q <= {22'h000000, control_reg_q};
        `ASPF_OFF_IFLS: rdata_q <= {26'h0000000, fifo_level_select_reg_q};
        `ASPF_OFF_LEVEL: rdata_q <= {22'h000000, rx_count, tx_count};
        default: rdata_q <= 32'h00000000;
      endcase
    end
    else
    begin
      rdata_q <= 32'h00000000;
    end
  end
  assign reg_rdata_out = rdata_q;
endmodule // aspf_port

// [tb/aspf_port_assertions.sv]
// Checker for the serial port: watches register strobes, read data, lines and status.
// Assumes it is bound to aspf_port and that software latches line settings on 0x02C.
`timescale 1ns/1ns
`include "aspf_defs.svh"
module aspf_port_assertions (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Register port
  input wire aspf_pkg::aspf_addr_type reg_addr_in,
  input wire aspf_pkg::aspf_word_type reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire aspf_pkg::aspf_word_type reg_rdata_out,
  // Serial lines and status
  input wire logic serial_in_line_in,
  input wire logic serial_out_line_out,
  input wire logic busy_out,
  input wire logic tx_level_hit_out,
  input wire logic rx_level_hit_out
);
  import aspf_pkg::*;
  logic fen_q;
  logic brk_q;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);
  // Mirror of the latched FIFO and break settings
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      fen_q <= 1'b0;
      brk_q <= 1'b0;
    end
    else if (reg_write_in && reg_addr_in == `ASPF_OFF_LCRH)
    begin
      fen_q <= reg_wdata_in[`ASPF_LCR_FEN];
      brk_q <= reg_wdata_in[`ASPF_LCR_BRK];
    end
  end
  sequence rd_flag;
    reg_read_in && reg_addr_in == `ASPF_OFF_FLAG;
  endsequence
  sequence low_run;
    !serial_out_line_out [*8];
  endsequence
  rdata_idle_a: assert property (!$past(reg_read_in) |-> reg_rdata_out == '0)
    else $error("read data not zero outside answer cycle");
  unmapped_zero_a: assert property (reg_read_in && reg_addr_in == 12'h100 |=> reg_rdata_out == '0)
    else $error("unmapped read not zero");
  busy_write_a: assert property (reg_write_in && reg_addr_in == `ASPF_OFF_DATA |=> busy_out)
    else $error("busy not set after data write");
  idle_high_a: assert property (!busy_out && !brk_q |-> serial_out_line_out)
    else $error("transmit line low while idle");
  break_low_a: assert property (brk_q |-> !serial_out_line_out)
    else $error("transmit line not low during break");
  start_len_a: assert property ($fell(serial_out_line_out) && !brk_q |-> low_run)
    else $error("start bit too short");
  stop_end_a: assert property ($fell(busy_out) |-> serial_out_line_out || brk_q)
    else $error("busy fell before stop bits done");
  tx_empty_a: assert property (!fen_q && !busy_out |-> tx_level_hit_out)
    else $error("transmit holding level wrong");
  flag_busy_a: assert property (rd_flag |=> reg_rdata_out[3] == $past(busy_out))
    else $error("busy flag differs from busy output");
  rx_empty_a: assert property (rd_flag and !fen_q |=> reg_rdata_out[4] != $past(rx_level_hit_out))
    else $error("receive empty flag wrong");
endmodule // aspf_port_assertions

bind aspf_port aspf_port_assertions aspf_port_assertions_i (
  .clk_sys_in(clk_sys_in),
  .sys_rst_in(sys_rst_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in),
  .reg_rdata_out(reg_rdata_out),
  .serial_in_line_in(serial_in_line_in),
  .serial_out_line_out(serial_out_line_out),
  .busy_out(busy_out),
  .tx_level_hit_out(tx_level_hit_out),
  .rx_level_hit_out(rx_level_hit_out)
);

// [tb/aspf_remote.sv]
// Remote serial station: sends frames to the port and captures its frames.
// Assumes one bit lasts bp system clocks, set by the testbench.
`timescale 1ns/1ns
module aspf_remote (
  // Clock
  input wire logic clk_sys_in,
  // Serial lines
  input wire logic line_from_dut_in,
  output logic line_to_dut_out
);
  int bp = 16;
  initial line_to_dut_out = 1'b1;
  // First bit first, then back to idle high
  task automatic send(input int n, input logic [11:0] f);
    @(posedge clk_sys_in);
    for (int i = 0; i < n; i++)
    begin
      line_to_dut_out <= f[i];
      repeat (bp) @(posedge clk_sys_in);
    end
    line_to_dut_out <= 1'b1;
  endtask
  // Ends mid last bit so back-to-back frames are not missed
  task automatic grab(input int n, output logic [11:0] f);
    f = '1;
    @(negedge line_from_dut_in);
    repeat (bp / 2) @(posedge clk_sys_in);
    for (int i = 0; i < n; i++)
    begin
      if (i > 0)
        repeat (bp) @(posedge clk_sys_in);
      f[i] = line_from_dut_in;
    end
  endtask
endmodule // aspf_remote

// [tb/tb.sv]
// Testbench for the serial port: register tasks, remote station, frame checks.
// Assumes a divisor of one gives sixteen clocks per bit.
`timescale 1ns/1ns
`include "aspf_defs.svh"
module tb;
  import aspf_pkg::*;
  logic clk_sys_in;
  logic sys_rst_in;
  aspf_addr_type ra;
  aspf_word_type wd;
  aspf_word_type rdat;
  aspf_word_type v;
  aspf_word_type lc;
  logic we;
  logic re;
  logic sin;
  logic sout;
  logic busy;
  logic txh;
  logic rxh;
  logic [11:0] f;
  logic [11:0] g;
  logic [7:0] dm;
  int n;
  int t;
  int err_count;
  int check_count;
  aspf_port aspf_port_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_addr_in(ra),
    .reg_wdata_in(wd), .reg_write_in(we), .reg_read_in(re), .reg_rdata_out(rdat),
    .serial_in_line_in(sin), .serial_out_line_out(sout), .busy_out(busy),
    .tx_level_hit_out(txh), .rx_level_hit_out(rxh));
  aspf_remote aspf_remote_i (.clk_sys_in(clk_sys_in), .line_from_dut_in(sout),
    .line_to_dut_out(sin));
  initial
  begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  task tick(input int k);
    repeat (k) @(posedge clk_sys_in);
  endtask
  task wr(input aspf_addr_type a, input aspf_word_type d);
    @(posedge clk_sys_in);
    ra <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk_sys_in);
    we <= 1'b0;
  endtask
  task rd(input aspf_addr_type a, output aspf_word_type d);
    @(posedge clk_sys_in);
    ra <= a;
    re <= 1'b1;
    @(posedge clk_sys_in);
    re <= 1'b0;
    #1 d = rdat;
  endtask
  task chk(input aspf_word_type got, input aspf_word_type exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task waitrx;
    for (int k = 0; k < 600 && rxh !== 1'b1; k++)
      @(posedge clk_sys_in);
  endtask
  task tdone;
    t++;
    $display("test %0d done", t);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Mode i: 0 none, 1 odd, 2 even, 3 stick high, 4 stick low; length 5 + i % 4
  function automatic void frm(input int i, input logic [7:0] d, output logic [11:0] fr,
    output int nb, output aspf_word_type l, output logic [7:0] m);
    int len;
    len = 5 + i % 4;
    m = d & (8'hFF >> (8 - len));
    l = {24'h0, i >= 3, 2'(len - 5), 1'b0, i % 2 == 1, i == 2 || i == 4, i != 0, 1'b0};
    fr = '1;
    fr[0] = 1'b0;
    for (int j = 0; j < len; j++)
      fr[j + 1] = m[j];
    nb = len + 1;
    if (i != 0)
    begin
      fr[nb] = (i == 1) ? ~^m : (i == 2) ? ^m : (i == 3);
      nb++;
    end
    nb = nb + 1 + i % 2;
  endfunction
  initial
  begin
    repeat (50000) @(posedge clk_sys_in);
    err_count++;
    end_of_test;
  end
  initial
  begin
    sys_rst_in = 1'b1;
    ra = '0;
    wd = '0;
    we = 1'b0;
    re = 1'b0;
    tick(12);
    sys_rst_in <= 1'b0;
    rd(`ASPF_OFF_CTL, v);
    chk(v, 32'h300);
    rd(`ASPF_OFF_IFLS, v);
    chk(v, 32'h12);
    rd(`ASPF_OFF_FLAG, v);
    chk(v & 32'hF8, 32'h90);
    rd(12'h100, v);
    chk(v, 32'h0);
    wr(`ASPF_OFF_IBRD, 32'h1);
    wr(`ASPF_OFF_LCRH, 32'h60);
    wr(`ASPF_OFF_CTL, 32'h301);
    // Short low pulse must not start a word
    aspf_remote_i.bp = 4;
    aspf_remote_i.send(1, 12'h0);
    aspf_remote_i.bp = 16;
    tick(300);
    rd(`ASPF_OFF_FLAG, v);
    chk(v & 32'h10, 32'h10);
    tdone;
    for (int i = 0; i < 5; i++)
    begin
      frm(i, 8'hC5 - 8'(i * 29), f, n, lc, dm);
      wr(`ASPF_OFF_CTL, 32'h300);
      wr(`ASPF_OFF_LCRH, lc);
      wr(`ASPF_OFF_CTL, 32'h301);
      wr(`ASPF_OFF_DATA, {24'h0, dm});
      aspf_remote_i.grab(n, g);
      chk({20'h0, g}, {20'h0, f});
      aspf_remote_i.send(n, f);
      waitrx;
      rd(`ASPF_OFF_DATA, v);
      chk(v, {24'h0, dm});
    end
    tdone;
    aspf_remote_i.send(n, f ^ 12'h040);
    waitrx;
    rd(`ASPF_OFF_DATA, v);
    chk(v & 32'h3FF, {22'h0, 2'h2, dm});
    aspf_remote_i.send(n, f & 12'hF7F);
    waitrx;
    rd(`ASPF_OFF_DATA, v);
    chk(v & 32'h1FF, {23'h0, 1'b1, dm});
    aspf_remote_i.send(n, 12'h0);
    waitrx;
    rd(`ASPF_OFF_DATA, v);
    chk(v & 32'h800, 32'h800);
    aspf_remote_i.send(n, f);
    aspf_remote_i.send(n, f);
    tick(20);
    rd(`ASPF_OFF_RSR, v);
    chk(v & 32'h8, 32'h8);
    rd(`ASPF_OFF_DATA, v);
    chk(v & 32'hFF, {24'h0, dm});
    wr(`ASPF_OFF_RSR, 32'h0);
    rd(`ASPF_OFF_RSR, v);
    chk(v & 32'h8, 32'h0);
    tdone;
    wr(`ASPF_OFF_CTL, 32'h300);
    wr(`ASPF_OFF_LCRH, 32'h70);
    for (int i = 0; i < 17; i++)
      wr(`ASPF_OFF_DATA, 32'(i));
    rd(`ASPF_OFF_FLAG, v);
    chk(v & 32'hA8, 32'h28);
    wr(`ASPF_OFF_CTL, 32'h301);
    for (int i = 0; i < 16; i++)
    begin
      aspf_remote_i.grab(10, g);
      chk({20'h0, g}, {20'h0, 3'h7, 8'(i), 1'b0});
    end
    for (int i = 0; i < 16; i++)
      aspf_remote_i.send(10, {2'h3, 8'(i + 64), 1'b0});
    tick(20);
    rd(`ASPF_OFF_FLAG, v);
    chk(v & 32'hC8, 32'hC0);
    for (int i = 0; i < 16; i++)
    begin
      chk({31'h0, rxh}, {31'h0, i <= 8});
      rd(`ASPF_OFF_DATA, v);
      chk(v, 32'(i + 64));
    end
    tdone;
    // Fraction alone is not taken until the line settings are written
    wr(`ASPF_OFF_CTL, 32'h300);
    wr(`ASPF_OFF_FBRD, 32'd32);
    wr(`ASPF_OFF_CTL, 32'h301);
    wr(`ASPF_OFF_DATA, 32'h5A);
    aspf_remote_i.grab(10, g);
    chk({20'h0, g}, 32'hEB4);
    wr(`ASPF_OFF_CTL, 32'h300);
    wr(`ASPF_OFF_LCRH, 32'h60);
    wr(`ASPF_OFF_CTL, 32'h301);
    aspf_remote_i.bp = 24;
    wr(`ASPF_OFF_DATA, 32'hA6);
    aspf_remote_i.grab(10, g);
    chk({20'h0, g}, 32'hF4C);
    tdone;
    wr(`ASPF_OFF_LCRH, 32'h61);
    tick(3);
    chk({31'h0, sout}, 32'h0);
    wr(`ASPF_OFF_LCRH, 32'h60);
    tick(3);
    wr(`ASPF_OFF_DATA, 32'h3C);
    fork
      aspf_remote_i.grab(10, g);
      begin
        tick(40);
        wr(`ASPF_OFF_CTL, 32'h300);
      end
    join
    chk({20'h0, g}, 32'hE78);
    tick(30);
    chk({31'h0, busy}, 32'h0);
    tdone;
    end_of_test;
  end
endmodule // tb
